// ### logic/tcio_pkg.sv
// Constants shared by the timer channel I/O control block.
package tcio_pkg;
    // ========================================================================
    // Register map (byte addresses)
    // ========================================================================
    localparam int unsigned ADDR_W       = 8;
    localparam int unsigned CNT_W        = 16;
    localparam logic [7:0]  OFF_IO_HIGH  = 8'h00;
    localparam logic [7:0]  OFF_IO_LOW   = 8'h04;
    localparam logic [7:0]  OFF_MODE     = 8'h08;
    localparam logic [7:0]  OFF_COUNTER  = 8'h0c;
    localparam logic [7:0]  OFF_GR_BASE  = 8'h10;
    localparam logic [7:0]  OFF_PINS     = 8'h20;

    // ========================================================================
    // Field layout and reset values
    // ========================================================================
    localparam int unsigned FLD_MODE_BIT = 3;
    localparam int unsigned FLD_INIT_BIT = 2;
    localparam int unsigned MODE_BFA_BIT = 0;
    localparam int unsigned MODE_BFB_BIT = 1;
    localparam int unsigned MODE_RUN_BIT = 2;
    localparam logic [7:0]  IO_RESET     = 8'h00;
    localparam logic [7:0]  MODE_RESET   = 8'h00;
    localparam logic [15:0] GR_RESET     = 16'hffff;

    // ========================================================================
    // Compare actions and bus responses
    // ========================================================================
    localparam logic [1:0]  ACT_NONE     = 2'h0;
    localparam logic [1:0]  ACT_LOW      = 2'h1;
    localparam logic [1:0]  ACT_HIGH     = 2'h2;
    localparam logic [1:0]  ACT_TOGGLE   = 2'h3;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;
endpackage : tcio_pkg

// ### logic/tcio_counter.sv
// Free-running channel counter with software load.
`timescale 1ns/1ps
module tcio_counter (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic        run,
    input  wire logic        load,
    input  wire logic [15:0] load_val,
    output logic      [15:0] count,
    output logic             updated
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        upd;
    } tcio_cnt_state_t;

    tcio_cnt_state_t s_q;
    tcio_cnt_state_t s_d;

    // ========================================================================
    // Counting
    // ========================================================================
    // A load wins over counting; upd marks a fresh value so a stopped
    // counter does not match the same register again every cycle.
    always_comb begin
        s_d     = s_q;
        s_d.upd = 1'b0;
        if (load) begin
            s_d.cnt = load_val;
            s_d.upd = 1'b1;
        end else if (run) begin
            s_d.cnt = s_q.cnt + 16'h0001;
            s_d.upd = 1'b1;
        end
    end

    // Clock enable freezes the counter.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign count   = s_q.cnt;
    assign updated = s_q.upd;
endmodule : tcio_counter

// ### logic/tcio_unit.sv
// Compare output and capture edge logic of one general register.
`timescale 1ns/1ps
module tcio_unit (
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    input  wire logic       clk_en,
    input  wire logic [3:0] field,
    input  wire logic       inhibit,
    input  wire logic       field_wr,
    input  wire logic       match,
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe,
    output logic            capture
);
    typedef struct packed {
        logic lvl;
        logic oe;
        logic prev;
    } tcio_unit_state_t;

    tcio_unit_state_t s_q;
    tcio_unit_state_t s_d;
    logic       is_cmp;
    logic [1:0] act;
    logic       rise;
    logic       fall;

    // ========================================================================
    // Compare output
    // ========================================================================
    // A new field loads the initial level before any match may act.
    always_comb begin
        is_cmp = ~field[tcio_pkg::FLD_MODE_BIT];
        act    = field[1:0];
        s_d    = s_q;
        s_d.prev = pin_in;
        s_d.oe = is_cmp & (act != tcio_pkg::ACT_NONE) & ~inhibit;
        if (field_wr) begin
            s_d.lvl = field[tcio_pkg::FLD_INIT_BIT];
        end else if (is_cmp && match && !inhibit) begin
            unique case (act)
                tcio_pkg::ACT_LOW:    s_d.lvl = 1'b0;
                tcio_pkg::ACT_HIGH:   s_d.lvl = 1'b1;
                tcio_pkg::ACT_TOGGLE: s_d.lvl = ~s_q.lvl;
                tcio_pkg::ACT_NONE:   s_d.lvl = s_q.lvl;
            endcase
        end
    end

    // ========================================================================
    // Capture edges
    // ========================================================================
    // Bit 2 does not change the edge choice; the own pin stays the source.
    always_comb begin
        rise = pin_in & ~s_q.prev;
        fall = ~pin_in & s_q.prev;
        if (act == tcio_pkg::ACT_NONE) begin
            capture = rise;
        end else if (act == tcio_pkg::ACT_LOW) begin
            capture = fall;
        end else begin
            capture = rise | fall;
        end
        capture = capture & clk_en & ~is_cmp & ~inhibit;
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q <= '0;
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    assign pin_out = s_q.lvl;
    assign pin_oe  = s_q.oe;

    // ========================================================================
    // Checks
    // ========================================================================
    chk_init_level: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && field_wr |=> pin_out == $past(field[2]))
        else $error("initial level not loaded");
    chk_drive_low: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && !field_wr && !inhibit && match && field[3:0] ==? 4'b0?01 |=> !pin_out)
        else $error("pin not driven low on match");
    chk_drive_high: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && !field_wr && !inhibit && match && field[3:0] ==? 4'b0?10 |=> pin_out)
        else $error("pin not driven high on match");
    chk_toggle_level: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && !field_wr && !inhibit && match && field[3:0] ==? 4'b0?11
        |=> pin_out != $past(pin_out))
        else $error("pin not toggled on match");
    chk_rise_capture: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && $past(clk_en) && !inhibit && field[3] && field[1:0] == 2'b00 && $rose(pin_in) |-> capture)
        else $error("rising edge not captured");
    chk_fall_capture: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && $past(clk_en) && !inhibit && field[3] && field[1:0] == 2'b01 && $fell(pin_in) |-> capture)
        else $error("falling edge not captured");
    chk_both_capture: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && !inhibit && field[3] && field[1] && pin_in != s_q.prev |-> capture)
        else $error("edge missed in both-edge mode");
    chk_output_off: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && (field[1:0] == 2'b00 || field[3] || inhibit) |=> !pin_oe)
        else $error("pin driven while output disabled");
    chk_inhibit_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        inhibit |-> !capture)
        else $error("capture while register is a buffer");
endmodule : tcio_unit

// ### logic/tcio_top.sv
// Timer channel I/O control: field registers, general registers, AXI4-Lite slave.
//
// The register addresses and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/1ps
module tcio_top (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [7:0]  s_axil_awaddr,
    input  wire logic        s_axil_awvalid,
    output logic             s_axil_awready,
    input  wire logic [31:0] s_axil_wdata,
    input  wire logic [3:0]  s_axil_wstrb,
    input  wire logic        s_axil_wvalid,
    output logic             s_axil_wready,
    output logic [1:0]       s_axil_bresp,
    output logic             s_axil_bvalid,
    input  wire logic        s_axil_bready,
    input  wire logic [7:0]  s_axil_araddr,
    input  wire logic        s_axil_arvalid,
    output logic             s_axil_arready,
    output logic [31:0]      s_axil_rdata,
    output logic [1:0]       s_axil_rresp,
    output logic             s_axil_rvalid,
    input  wire logic        s_axil_rready,
    input  wire logic [3:0]  pin_in,
    output logic      [3:0]  pin_out,
    output logic      [3:0]  pin_oe
);
    // ========================================================================
    // State
    // ========================================================================
    // Index 0..3 stands for general registers A, B, C and D.
    typedef struct packed {
        logic             aw_got;
        logic [7:0]       aw_addr;
        logic             w_got;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             awready;
        logic             wready;
        logic             bvalid;
        logic [1:0]       bresp;
        logic             arready;
        logic             rvalid;
        logic [1:0]       rresp;
        logic [31:0]      rdata;
        logic [7:0]       io_control_high;
        logic [7:0]       io_control_low;
        logic [7:0]       channel_mode_register;
        logic [3:0][15:0] gr;
        logic [3:0]       fwr;
    } tcio_top_state_t;

    tcio_top_state_t s_q;
    tcio_top_state_t s_d;
    logic            do_wr;
    logic            cnt_load;
    logic [15:0]     count;
    logic            cnt_upd;
    logic [3:0][3:0] field;
    logic [3:0]      inhibit;
    logic [3:0]      match;
    logic [3:0]      capture;
    logic [3:0]      unit_out;
    logic [3:0]      unit_oe;

    // ========================================================================
    // Field decode
    // ========================================================================
    // Each control register carries two 4-bit fields, the upper one for B/D.
    always_comb begin
        field[0] = s_q.io_control_high[3:0];
        field[1] = s_q.io_control_high[7:4];
        field[2] = s_q.io_control_low[3:0];
        field[3] = s_q.io_control_low[7:4];
        inhibit[0] = 1'b0;
        inhibit[1] = 1'b0;
        inhibit[2] = s_q.channel_mode_register[tcio_pkg::MODE_BFA_BIT];
        inhibit[3] = s_q.channel_mode_register[tcio_pkg::MODE_BFB_BIT];
    end

    // ========================================================================
    // Counter and per-register units
    // ========================================================================
    tcio_counter u_counter (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .clk_en   (clk_en),
        .run      (s_q.channel_mode_register[tcio_pkg::MODE_RUN_BIT]),
        .load     (cnt_load),
        .load_val (s_q.w_data[15:0]),
        .count    (count),
        .updated  (cnt_upd)
    );

    // A match counts only when the counter has just taken a new value.
    for (genvar i = 0; i < 4; i++) begin : g_unit
        assign match[i] = cnt_upd & (count == s_q.gr[i]);
        tcio_unit u_unit (
            .mclk     (mclk),
            .sys_rst  (sys_rst),
            .clk_en   (clk_en),
            .field    (field[i]),
            .inhibit  (inhibit[i]),
            .field_wr (s_q.fwr[i]),
            .match    (match[i]),
            .pin_in   (pin_in[i]),
            .pin_out  (unit_out[i]),
            .pin_oe   (unit_oe[i]),
            .capture  (capture[i])
        );
    end

    // ========================================================================
    // Bus slave and register file
    // ========================================================================
    // Address and data are taken in either order; the write is done once both
    // are held, and no new write is taken until the response is accepted.
    always_comb begin
        s_d      = s_q;
        s_d.fwr  = 4'h0;
        do_wr    = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
        cnt_load = 1'b0;
        if (s_q.bvalid && s_axil_bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_axil_awvalid && s_q.awready) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axil_awaddr;
        end
        if (s_axil_wvalid && s_q.wready) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axil_wdata;
            s_d.w_strb = s_axil_wstrb;
        end
        if (do_wr) begin
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
            s_d.bvalid = 1'b1;
            s_d.bresp  = tcio_pkg::RESP_OKAY;
            if (s_q.aw_addr[7:2] == tcio_pkg::OFF_IO_HIGH[7:2]) begin
                if (s_q.w_strb[0]) begin
                    s_d.io_control_high = s_q.w_data[7:0];
                    s_d.fwr[1:0]        = 2'h3;
                end
            end else if (s_q.aw_addr[7:2] == tcio_pkg::OFF_IO_LOW[7:2]) begin
                if (s_q.w_strb[0]) begin
                    s_d.io_control_low = s_q.w_data[7:0];
                    s_d.fwr[3:2]       = 2'h3;
                end
            end else if (s_q.aw_addr[7:2] == tcio_pkg::OFF_MODE[7:2]) begin
                if (s_q.w_strb[0]) begin
                    s_d.channel_mode_register = s_q.w_data[7:0];
                end
            end else if (s_q.aw_addr[7:2] == tcio_pkg::OFF_COUNTER[7:2]) begin
                cnt_load = 1'b1;
            end else if (s_q.aw_addr[7:4] == tcio_pkg::OFF_GR_BASE[7:4]) begin
                for (int b = 0; b < 2; b++) begin
                    if (s_q.w_strb[b]) begin
                        s_d.gr[s_q.aw_addr[3:2]][b*8 +: 8] = s_q.w_data[b*8 +: 8];
                    end
                end
            end else begin
                s_d.bresp = tcio_pkg::RESP_SLVERR;
            end
        end
        // A capture edge wins over a software write in the same cycle.
        for (int i = 0; i < 4; i++) begin
            if (capture[i]) begin
                s_d.gr[i] = count;
            end
        end
        s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
        s_d.wready  = ~s_d.w_got & ~s_d.bvalid;

        // Read path: one read at a time, data held until rready. It lives in
        // the one next-state process, since no second process may write the
        // state copy.
        if (s_q.rvalid && s_axil_rready) begin
            s_d.rvalid = 1'b0;
        end
        if (s_axil_arvalid && s_q.arready) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = tcio_pkg::RESP_OKAY;
            s_d.rdata  = 32'h0000_0000;
            if (s_axil_araddr[7:2] == tcio_pkg::OFF_IO_HIGH[7:2]) begin
                s_d.rdata[7:0] = s_q.io_control_high;
            end else if (s_axil_araddr[7:2] == tcio_pkg::OFF_IO_LOW[7:2]) begin
                s_d.rdata[7:0] = s_q.io_control_low;
            end else if (s_axil_araddr[7:2] == tcio_pkg::OFF_MODE[7:2]) begin
                s_d.rdata[7:0] = s_q.channel_mode_register;
            end else if (s_axil_araddr[7:2] == tcio_pkg::OFF_COUNTER[7:2]) begin
                s_d.rdata[15:0] = count;
            end else if (s_axil_araddr[7:4] == tcio_pkg::OFF_GR_BASE[7:4]) begin
                s_d.rdata[15:0] = s_q.gr[s_axil_araddr[3:2]];
            end else if (s_axil_araddr[7:2] == tcio_pkg::OFF_PINS[7:2]) begin
                s_d.rdata[11:0] = {pin_in, unit_oe, unit_out};
            end else begin
                s_d.rresp = tcio_pkg::RESP_SLVERR;
            end
        end
        s_d.arready = ~s_d.rvalid;
    end

    // Reset returns every field to code 0000, which keeps all pins undriven.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            s_q                       <= '0;
            s_q.io_control_high       <= tcio_pkg::IO_RESET;
            s_q.io_control_low        <= tcio_pkg::IO_RESET;
            s_q.channel_mode_register <= tcio_pkg::MODE_RESET;
            s_q.gr                    <= {4{tcio_pkg::GR_RESET}};
        end else if (clk_en) begin
            s_q <= s_d;
        end
    end

    // ========================================================================
    // Outputs
    // ========================================================================
    // Ready signals are registered, so they rise one cycle after reset.
    assign s_axil_awready = s_q.awready;
    assign s_axil_wready  = s_q.wready;
    assign s_axil_bvalid  = s_q.bvalid;
    assign s_axil_bresp   = s_q.bresp;
    assign s_axil_arready = s_q.arready;
    assign s_axil_rvalid  = s_q.rvalid;
    assign s_axil_rresp   = s_q.rresp;
    assign s_axil_rdata   = s_q.rdata;
    assign pin_out        = unit_out;
    assign pin_oe         = unit_oe;

    // ========================================================================
    // Checks
    // ========================================================================
    chk_capture_copy: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && capture[0] |=> s_q.gr[0] == $past(count))
        else $error("capture did not copy counter");
    chk_high_write: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && do_wr && s_q.w_strb[0] && s_q.aw_addr == tcio_pkg::OFF_IO_HIGH
        |=> s_q.io_control_high == $past(s_q.w_data[7:0]) && s_q.fwr == 4'h3)
        else $error("high control write lost");
    chk_low_write: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && do_wr && s_q.w_strb[0] && s_q.aw_addr == tcio_pkg::OFF_IO_LOW
        |=> s_q.io_control_low == $past(s_q.w_data[7:0]) && s_q.fwr == 4'hc)
        else $error("low control write lost");
    chk_reset_fields: assert property (@(posedge mclk)
        $past(sys_rst) && !sys_rst |-> s_q.io_control_high == 8'h00 && s_q.io_control_low == 8'h00)
        else $error("control fields not cleared by reset");
    chk_buffer_d_off: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && s_q.channel_mode_register[1] |-> !capture[3] ##1 !pin_oe[3])
        else $error("register D active in buffer mode");
    chk_buffer_c_off: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && s_q.channel_mode_register[0] |-> !capture[2] ##1 !pin_oe[2])
        else $error("register C active in buffer mode");
    // The field decode must place each nibble on its own register.
    chk_high_fields: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && do_wr && s_q.w_strb[0] && s_q.aw_addr == tcio_pkg::OFF_IO_HIGH
        |=> field[1] == $past(s_q.w_data[7:4]) && field[0] == $past(s_q.w_data[3:0]))
        else $error("high control fields misplaced");
    chk_low_fields: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && do_wr && s_q.w_strb[0] && s_q.aw_addr == tcio_pkg::OFF_IO_LOW
        |=> field[3] == $past(s_q.w_data[7:4]) && field[2] == $past(s_q.w_data[3:0]))
        else $error("low control fields misplaced");
    chk_capture_c: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && capture[2] |=> s_q.gr[2] == $past(count))
        else $error("capture did not copy counter into register C");
endmodule : tcio_top

// ### sim/tcio_pin_model.sv
// Pin-side model of the four compare/capture pins of the channel.
`timescale 1ns/1ps
module tcio_pin_model (
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    input  wire logic [3:0] ext_level,
    output logic      [3:0] pin_in
);
    // ========================================================================
    // Pin resolution
    // ========================================================================
    // A driven pin reads back the block's level; an undriven pin shows the outside level.
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule : tcio_pin_model

// ### sim/timer_ch3_io_control_bench.sv
// Self-checking bench of the timer channel I/O control block.
`timescale 1ns/1ps
module timer_ch3_io_control_bench;
    // ========================================================================
    // Signals
    // ========================================================================
    logic        mclk = 1'h0, sys_rst = 1'h1, clk_en = 1'h1;
    logic [7:0]  s_axil_awaddr = 8'h00, s_axil_araddr = 8'h00;
    logic [31:0] s_axil_wdata = 32'h0, s_axil_rdata, rdat;
    logic [3:0]  s_axil_wstrb = 4'hf, pin_in, pin_out, pin_oe, ext_level = 4'h0;
    logic        s_axil_awvalid = 1'h0, s_axil_wvalid = 1'h0, s_axil_bready = 1'h0;
    logic        s_axil_arvalid = 1'h0, s_axil_rready = 1'h0;
    logic        s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
    logic [1:0]  s_axil_bresp, s_axil_rresp, resp;
    int          mismatches = 0, comparisons = 0;
    // Each row: field code, then oe/rise, initial/fall, level after one match.
    logic [7:0]  rows [16] = '{8'h00, 8'h18, 8'h2a, 8'h3a, 8'h46, 8'h5c, 8'h6e, 8'h7c,
                               8'h88, 8'h94, 8'hac, 8'hbc, 8'hc8, 8'hd4, 8'hec, 8'hfc};

    tcio_top tcio_top_i (.mclk, .sys_rst, .clk_en, .s_axil_awaddr, .s_axil_awvalid, .s_axil_awready,
        .s_axil_wdata, .s_axil_wstrb, .s_axil_wvalid, .s_axil_wready, .s_axil_bresp, .s_axil_bvalid,
        .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rdata, .s_axil_rresp,
        .s_axil_rvalid, .s_axil_rready, .pin_in, .pin_out, .pin_oe);
    tcio_pin_model tcio_pin_model_i (.pin_out, .pin_oe, .ext_level, .pin_in);

    // The clock runs at 40 MHz.
    always #12.5 mclk = ~mclk;

    // ========================================================================
    // Tasks
    // ========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : chk

    // Ready is registered, so sampling it at the falling edge tells what the next rising edge takes.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_p;
        logic w_p;
        aw_p = 1'h1;
        w_p = 1'h1;
        @(posedge mclk);
        s_axil_awaddr <= a;
        s_axil_wdata <= d;
        s_axil_awvalid <= 1'h1;
        s_axil_wvalid <= 1'h1;
        while (aw_p || w_p) begin
            @(negedge mclk);
            if (s_axil_awready) aw_p = 1'h0;
            if (s_axil_wready) w_p = 1'h0;
            @(posedge mclk);
            s_axil_awvalid <= aw_p;
            s_axil_wvalid <= w_p;
        end
        s_axil_bready <= 1'h1;
        do @(negedge mclk); while (s_axil_bvalid !== 1'h1);
        resp = s_axil_bresp;
        @(posedge mclk);
        s_axil_bready <= 1'h0;
    endtask : wr

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        s_axil_araddr <= a;
        s_axil_arvalid <= 1'h1;
        do @(negedge mclk); while (s_axil_arready !== 1'h1);
        @(posedge mclk);
        s_axil_arvalid <= 1'h0;
        s_axil_rready <= 1'h1;
        do @(negedge mclk); while (s_axil_rvalid !== 1'h1);
        rdat = s_axil_rdata;
        resp = s_axil_rresp;
        @(posedge mclk);
        s_axil_rready <= 1'h0;
        chk(rdat, exp);
    endtask : rdchk

    task automatic give_verdict();
        if (mismatches == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : give_verdict

    // ========================================================================
    // Sequence
    // ========================================================================
    // Rows drive register A's field through all sixteen codes with the counter stopped or running.
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'h0;
        repeat (2) @(posedge mclk);
        chk(pin_oe, 32'h0);
        rdchk(tcio_pkg::OFF_IO_HIGH, 32'h0);
        rdchk(tcio_pkg::OFF_IO_LOW, 32'h0);
        for (int i = 0; i < 16; i++) begin
            wr(tcio_pkg::OFF_GR_BASE, i < 8 ? 32'h10 : 32'hffff);
            wr(tcio_pkg::OFF_COUNTER, i < 8 ? 32'h8 : 32'h1230 + i);
            wr(tcio_pkg::OFF_IO_HIGH, {28'h0, rows[i][7:4]});
            repeat (3) @(posedge mclk);
            if (i < 8) begin
                chk(pin_oe[0], rows[i][3]);
                if (rows[i][3]) chk(pin_out[0], rows[i][2]);
                wr(tcio_pkg::OFF_MODE, 32'h4);
                repeat (20) @(posedge mclk);
                wr(tcio_pkg::OFF_MODE, 32'h0);
                if (rows[i][3]) chk(pin_out[0], rows[i][1]);
            end else begin
                ext_level[0] <= 1'h1;
                repeat (3) @(posedge mclk);
                rdchk(tcio_pkg::OFF_GR_BASE, rows[i][3] ? 32'h1230 + i : 32'hffff);
                wr(tcio_pkg::OFF_GR_BASE, 32'hffff);
                ext_level[0] <= 1'h0;
                repeat (3) @(posedge mclk);
                rdchk(tcio_pkg::OFF_GR_BASE, rows[i][2] ? 32'h1230 + i : 32'hffff);
            end
        end
        // Field placement and the two buffer-mode bits.
        wr(tcio_pkg::OFF_IO_HIGH, 32'h30);
        repeat (3) @(posedge mclk);
        chk(pin_oe, 32'h2);
        wr(tcio_pkg::OFF_IO_HIGH, 32'h0);
        wr(tcio_pkg::OFF_IO_LOW, 32'h21);
        repeat (3) @(posedge mclk);
        chk(pin_oe, 32'hc);
        wr(tcio_pkg::OFF_MODE, 32'h1);
        repeat (3) @(posedge mclk);
        chk(pin_oe, 32'h8);
        wr(tcio_pkg::OFF_MODE, 32'h2);
        repeat (3) @(posedge mclk);
        chk(pin_oe, 32'h4);
        wr(tcio_pkg::OFF_IO_LOW, 32'h88);
        chk(resp, tcio_pkg::RESP_OKAY);
        wr(tcio_pkg::OFF_GR_BASE + 8'h08, 32'hffff);
        wr(tcio_pkg::OFF_GR_BASE + 8'h0c, 32'hffff);
        wr(tcio_pkg::OFF_COUNTER, 32'habc);
        ext_level[3:2] <= 2'h3;
        repeat (3) @(posedge mclk);
        rdchk(tcio_pkg::OFF_GR_BASE + 8'h08, 32'habc);
        rdchk(tcio_pkg::OFF_GR_BASE + 8'h0c, 32'hffff);
        rdchk(tcio_pkg::OFF_PINS, 32'hc00);
        rdchk(tcio_pkg::OFF_COUNTER, 32'habc);
        chk(resp, tcio_pkg::RESP_OKAY);
        // A rise while the enable is low must still be seen once it returns.
        ext_level[2] <= 1'h0;
        wr(tcio_pkg::OFF_GR_BASE + 8'h08, 32'hffff);
        clk_en <= 1'h0;
        ext_level[2] <= 1'h1;
        repeat (4) @(posedge mclk);
        clk_en <= 1'h1;
        repeat (3) @(posedge mclk);
        rdchk(tcio_pkg::OFF_GR_BASE + 8'h08, 32'habc);
        // Unmapped places answer with an error and no data.
        wr(8'h24, 32'h1);
        chk(resp, tcio_pkg::RESP_SLVERR);
        rdchk(8'h30, 32'h0);
        chk(resp, tcio_pkg::RESP_SLVERR);
        // A reset in mid-run clears the control fields again.
        sys_rst <= 1'h1;
        repeat (8) @(posedge mclk);
        sys_rst <= 1'h0;
        repeat (2) @(posedge mclk);
        rdchk(tcio_pkg::OFF_IO_LOW, 32'h0);
        give_verdict();
    end

    // The whole sequence needs roughly a thousand cycles; this limit leaves ample margin.
    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        give_verdict();
    end
endmodule : timer_ch3_io_control_bench
